// file: sim/lmr_mem_model.sv
module lmr_mem_model
    import lmr_pkg::*;
(
    // clock, reset
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    // memory bus, bench settings
    input  wire lmr_mem_req_s mem_req,
    input  wire lmr_mem_rsp_s attr,
    input  wire logic [3:0]   lat,
    output lmr_mem_rsp_s      mem_rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt;
    // attributes inverted outside done, so a late sample shows up
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 4'h0;
            mem_rsp <= '0;
        end else begin
            mem_rsp <= {1'h0, ~attr[3:0]};
            cnt <= 4'h0;
            if (mem_req.valid && !mem_rsp.done && cnt >= lat)
                mem_rsp <= {1'h1, attr[3:0]};
            else if (mem_req.valid && !mem_rsp.done)
                cnt <= cnt + 4'h1;
        end
    end
endmodule

// file: sim/lmr_read_state_bench.sv
module lmr_read_state_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import lmr_pkg::*;
    // index, {lock,split,pcd,pwt,dat}, {memory_cacheable_hint,mro,mwt,direct_to_modified_hint}, {array,force,l1,tro,cycle,state}
    localparam logic [23:0] ROWS [16] = '{
        {5'd0, 5'b00001, 4'hc, 10'b0101001001}, {5'd1, 5'b00000, 4'hc, 10'b0111001001},
        {5'd2, 5'b00011, 4'h8, 10'b0110001001}, {5'd3, 5'b00001, 4'ha, 10'b0110001001},
        {5'd4, 5'b00001, 4'h8, 10'b0110001010}, {5'd5, 5'b00001, 4'h9, 10'b0110001011},
        {5'd6, 5'b00101, 4'h8, 10'b0100001100}, {5'd7, 5'b11001, 4'h8, 10'b0100001100},
        {5'd0, 5'b00001, 4'h8, 10'b1101000001}, {5'd1, 5'b00000, 4'h8, 10'b1111000001},
        {5'd5, 5'b00001, 4'h8, 10'b1010000011}, {5'd5, 5'b11001, 4'h8, 10'b1100000111},
        {5'd4, 5'b00001, 4'h8, 10'b1110000010}, {5'd4, 5'b11001, 4'h8, 10'b0100000110},
        {5'd2, 5'b10001, 4'h8, 10'b0100000101}, {5'd21, 5'b00001, 4'h8, 10'b0110001010}};
    logic         ref_clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, err;
    logic [31:0]  paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic [3:0]   lat = 4'h0;
    lmr_cpu_req_s cpu_req = '0;
    lmr_cpu_rsp_s cpu_rsp;
    lmr_mem_req_s mem_req;
    lmr_mem_rsp_s mem_rsp, attr = '0;
    int           fails = 0, samples_checked = 0, cycles = 0;
    wire logic [2:0] obs = {cpu_rsp.from_array, cpu_rsp.shared_force, cpu_rsp.l1_allow};
    lmr_read_state dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .cpu_req, .cpu_rsp, .mem_req, .mem_rsp);
    lmr_mem_model mem_i (.ref_clk, .rst_n, .mem_req, .attr, .lat, .mem_rsp);
    task automatic stop_test();
        $display("fails %0d samples_checked %0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // one idle edge after release so back-to-back calls never drive psel twice in a step
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'h1, wr, a, d};
        @(posedge ref_clk) penable <= 1'h1;
        do @(posedge ref_clk); while (pready !== 1'h1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
        @(posedge ref_clk);
    endtask
    task automatic req(input logic [4:0] f, input logic [4:0] ix);
        cpu_req.valid <= 1'h1;
        cpu_req.addr <= 32'h200 + {ix, 5'h0};
        {cpu_req.lock, cpu_req.split, cpu_req.page_cache_disable, cpu_req.page_write_through, cpu_req.dat} <= f;
        @(posedge ref_clk) cpu_req.valid <= 1'h0;
        do @(posedge ref_clk); while (cpu_rsp.done !== 1'h1);
    endtask
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'h1;
        @(posedge ref_clk);
        apb(1'h0, ADDR_CTRL, 32'h0);
        chk(rd, 32'h1);
        apb(1'h0, 32'h14, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        $display("register test done");
        foreach (ROWS[i]) begin
            attr <= {1'h0, ROWS[i][13:10]};
            lat <= 4'(i % 3);
            req(ROWS[i][18:14], ROWS[i][23:19]);
            apb(1'h0, ADDR_STATUS, 32'h0);
            chk(rd[6:0], ROWS[i][6:0]);
            chk(obs, ROWS[i][9:7]);
            $display("row %0d done", i);
        end
        cpu_req.write <= 1'h1;
        cpu_req.data  <= 32'h5a5a0001;
        req(5'b00001, 5'd8);
        apb(1'h0, ADDR_STATUS, 32'h0);
        chk(rd[6:0], 32'h1a);
        req(5'b00101, 5'd9);
        apb(1'h0, ADDR_STATUS, 32'h0);
        chk(rd[6:0], 32'h12);
        cpu_req.write <= 1'h0;
        apb(1'h0, ADDR_HITS, 32'h0);
        chk(rd, 32'h7);
        $display("write test done");
        apb(1'h1, ADDR_TAG_SEL, 32'h1);
        apb(1'h0, ADDR_TAG_DATA, 32'h0);
        chk(rd[10:0], 11'h301);
        apb(1'h1, ADDR_TAG_DATA, 32'h4ab);
        apb(1'h0, ADDR_TAG_DATA, 32'h0);
        chk(rd[10:0], 11'h4ab);
        apb(1'h1, ADDR_CTRL, 32'h3);
        for (int k = 0; k < 20 && cpu_rsp.snoop_valid !== 1'h1; k++) @(posedge ref_clk);
        chk(cpu_rsp.snoop_discard, 1'h1);
        chk(cpu_rsp.snoop_addr, 32'h200);
        $display("purge test done");
        stop_test();
    end
endmodule

// file: sim/lmr_read_state_sva.sv
module lmr_read_state_sva
    import lmr_pkg::*;
(
    // clock, reset, apb
    input wire logic         ref_clk, rst_n, psel, penable, pwrite, pready, pslverr,
    input wire logic [31:0]  paddr, pwdata, prdata,
    // cpu and memory sides
    input wire lmr_cpu_req_s cpu_req,
    input wire lmr_cpu_rsp_s cpu_rsp,
    input wire lmr_mem_req_s mem_req,
    input wire lmr_mem_rsp_s mem_rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic dat_q, pcd_q;
    logic [31:0] addr_q, data_q;
    wire  mem_end  = mem_req.valid && mem_rsp.done;
    wire  fill_end = mem_end && mem_req.cycle == CYC_LINE_FILL && mem_rsp.memory_cacheable_hint;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            {dat_q, pcd_q, addr_q, data_q} <= 66'h0;
        else if (cpu_req.valid)
            {dat_q, pcd_q, addr_q, data_q} <= {cpu_req.dat, cpu_req.page_cache_disable, cpu_req.addr, cpu_req.data};
    end
    a_snoop_discard: assert property (cpu_rsp.snoop_valid |-> cpu_rsp.snoop_discard)
        else $error("snoop without discard");
    a_copy_whole: assert property (mem_req.valid && mem_req.cycle == CYC_COPY_BACK |-> mem_req.whole_line)
        else $error("partial copy back");
    a_read_through_cycle_no_l1: assert property (mem_end && mem_req.cycle == CYC_READ_THRU |=> cpu_rsp.done && !cpu_rsp.l1_allow)
        else $error("read through result wrong");
    a_nc_no_l1: assert property (mem_end && mem_req.cycle == CYC_NC_READ |=> cpu_rsp.done && !cpu_rsp.l1_allow)
        else $error("uncached read result wrong");
    a_fill_sram: assert property (fill_end |=> cpu_rsp.sram_write)
        else $error("fill without array update");
    a_fill_force: assert property (fill_end |=> cpu_rsp.shared_force)
        else $error("fill released cpu write-through");
    a_ro_l1: assert property (fill_end && mem_rsp.memory_readonly_hint |=> cpu_rsp.l1_allow == !dat_q)
        else $error("read-only fill l1 wrong");
    a_pcd_no_fill: assert property (mem_req.valid && pcd_q |-> mem_req.cycle != CYC_LINE_FILL)
        else $error("fill despite page disable");
    a_write_through_cycle_copy: assert property (mem_req.valid && mem_req.cycle == CYC_WRITE_THRU
        |-> mem_req.addr == addr_q && mem_req.data == data_q)
        else $error("write through differs from cpu");
    cover property (mem_req.valid && mem_req.cycle == CYC_WMISS_FILL);
    cover property (cpu_rsp.snoop_valid);
    cover property (mem_end && mem_req.cycle == CYC_COPY_BACK);
    cover property (cpu_rsp.done && !cpu_rsp.shared_force);
endmodule
bind lmr_read_state lmr_read_state_sva chk_i (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cpu_req, .cpu_rsp, .mem_req, .mem_rsp);

// file: src/lmr_pkg.sv
package lmr_pkg;

    // cache geometry
    localparam int SET_BITS = 4;
    localparam int NUM_SETS = 16;
    localparam int TAG_W    = 8;
    localparam int LINE_LSB = 5;
    localparam int TAG_LSB  = 9;

    // apb register byte offsets
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_TAG_SEL  = 8'h08;
    localparam logic [7:0] ADDR_TAG_DATA = 8'h0c;
    localparam logic [7:0] ADDR_HITS     = 8'h10;

    // control fields and reset values
    localparam int          CTRL_EN_BIT    = 0;
    localparam int          CTRL_PURGE_BIT = 1;
    localparam logic        CTRL_EN_RESET  = 1'b1;
    localparam logic [3:0]  TAG_SEL_RESET  = 4'h0;

    // tag data fields
    localparam int TD_TAG_LSB = 0;
    localparam int TD_TRO_BIT = 8;
    localparam int TD_ST_LSB  = 9;

    // status fields
    localparam int SR_NEXT_LSB  = 0;
    localparam int SR_CYC_LSB   = 2;
    localparam int SR_TRO_BIT   = 6;
    localparam int SR_STATE_LSB = 8;

    typedef enum logic [1:0] {
        MESI_I = 2'b00,
        MESI_S = 2'b01,
        MESI_E = 2'b10,
        MESI_M = 2'b11
    } lmr_mesi_e;

    typedef enum logic [3:0] {
        CYC_NONE       = 4'b0000,
        CYC_READ_THRU  = 4'b0001,
        CYC_LINE_FILL  = 4'b0010,
        CYC_NC_READ    = 4'b0011,
        CYC_WRITE_THRU = 4'b0100,
        CYC_COPY_BACK  = 4'b0101,
        CYC_WMISS_FILL = 4'b0110
    } lmr_cyc_e;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_INQ   = 3'b001,
        ST_COPY  = 3'b010,
        ST_FETCH = 3'b011,
        ST_THRU  = 3'b100,
        ST_WRITE = 3'b101,
        ST_WRITE_MISS_FILL = 3'b110
    } lmr_state_e;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0]  be;
        logic        lock;
        logic        split;
        logic        page_cache_disable;
        logic        page_write_through;
        logic        dat;
    } lmr_cpu_req_s;

    typedef struct packed {
        logic        done;
        logic        l1_allow;
        logic        shared_force;
        logic        from_array;
        logic        sram_write;
        logic        snoop_valid;
        logic        snoop_discard;
        logic [31:0] snoop_addr;
    } lmr_cpu_rsp_s;

    typedef struct packed {
        logic        valid;
        lmr_cyc_e    cycle;
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0]  be;
        logic        whole_line;
    } lmr_mem_req_s;

    typedef struct packed {
        logic done;
        logic memory_cacheable_hint;
        logic memory_readonly_hint;
        logic memory_write_through_hint;
        logic direct_to_modified_hint;
    } lmr_mem_rsp_s;

endpackage

// file: src/lmr_read_state.sv
module lmr_read_state
    import lmr_pkg::*;
(
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    // apb slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [31:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    // cpu bus
    input  wire lmr_cpu_req_s cpu_req,
    output lmr_cpu_rsp_s      cpu_rsp,
    // memory bus
    output lmr_mem_req_s      mem_req,
    input  wire lmr_mem_rsp_s mem_rsp
);

    lmr_state_e        state_reg;
    lmr_cpu_req_s      req_reg;
    lmr_cpu_rsp_s      rsp_reg;
    lmr_mem_req_s      mreq_reg;
    lmr_mesi_e         st_arr [NUM_SETS];
    logic              tro_arr [NUM_SETS];
    logic [TAG_W-1:0]  tag_arr [NUM_SETS];
    logic              hit_reg;
    logic [31:0]       hits_reg;
    lmr_mesi_e         last_next_reg;
    lmr_cyc_e          last_cyc_reg;
    logic              last_tro_reg;

    logic              en_reg;
    logic [3:0]        tag_sel_reg;
    logic              purge_pend_reg;
    logic [3:0]        purge_idx_reg;
    logic              tdw_pend_reg;
    logic [31:0]       tdw_data_reg;
    logic [31:0]       prdata_reg;
    logic              pready_reg;
    logic              pslverr_reg;

    // request decode
    logic [SET_BITS-1:0] in_idx;
    logic [TAG_W-1:0]    in_tag;
    logic [SET_BITS-1:0] rq_idx;
    logic [TAG_W-1:0]    rq_tag;
    lmr_mesi_e           in_st;
    logic                in_hit;
    logic                in_sl;
    logic                rq_sl;
    logic                cpu_go;
    logic                purge_take;
    logic                tdw_take;
    logic                fill_nc;
    lmr_mesi_e           fill_st;
    logic [31:0]         victim_addr;
    logic [31:0]         purge_addr;
    logic                write_miss_fill_ok;

    always_comb begin
        in_idx = cpu_req.addr[LINE_LSB +: SET_BITS];
        in_tag = cpu_req.addr[TAG_LSB +: TAG_W];
        rq_idx = req_reg.addr[LINE_LSB +: SET_BITS];
        rq_tag = req_reg.addr[TAG_LSB +: TAG_W];
        in_st  = st_arr[in_idx];
        in_hit = (in_st != MESI_I) && (tag_arr[in_idx] == in_tag);
        in_sl  = cpu_req.lock & cpu_req.split;
        rq_sl  = req_reg.lock & req_reg.split;
    end

    always_comb begin
        cpu_go     = (state_reg == ST_IDLE) && en_reg && cpu_req.valid;
        purge_take = (state_reg == ST_IDLE) && !cpu_go && purge_pend_reg;
        tdw_take   = (state_reg == ST_IDLE) && !cpu_go && !purge_take && tdw_pend_reg;
    end

    // fill outcome, checked in the listed order
    always_comb begin
        fill_nc = req_reg.page_cache_disable | !mem_rsp.memory_cacheable_hint | rq_sl;
        if (mem_rsp.memory_readonly_hint) begin
            fill_st = MESI_S;
        end else if (req_reg.page_write_through || mem_rsp.memory_write_through_hint) begin
            fill_st = MESI_S;
        end else if (mem_rsp.direct_to_modified_hint) begin
            fill_st = MESI_M;
        end else begin
            fill_st = MESI_E;
        end
    end

    always_comb begin
        victim_addr = 32'h0;
        victim_addr[LINE_LSB +: SET_BITS] = rq_idx;
        victim_addr[TAG_LSB +: TAG_W] = tag_arr[rq_idx];
        purge_addr = 32'h0;
        purge_addr[LINE_LSB +: SET_BITS] = purge_idx_reg;
        purge_addr[TAG_LSB +: TAG_W] = tag_arr[purge_idx_reg];
        // allocation would overwrite a dirty victim, so it is skipped then
        write_miss_fill_ok = !hit_reg && !req_reg.page_cache_disable && !req_reg.page_write_through && !req_reg.lock
                   && mem_rsp.memory_cacheable_hint && (st_arr[rq_idx] != MESI_M);
    end

    // main sequencer, tag store and cpu/memory outputs
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= ST_IDLE;
            req_reg       <= '0;
            rsp_reg       <= '0;
            mreq_reg      <= '0;
            hit_reg       <= 1'b0;
            hits_reg      <= 32'h0;
            last_next_reg <= MESI_I;
            last_cyc_reg  <= CYC_NONE;
            last_tro_reg  <= 1'b0;
            for (int i = 0; i < NUM_SETS; i++) begin
                st_arr[i]  <= MESI_I;
                tro_arr[i] <= 1'b0;
                tag_arr[i] <= '0;
            end
        end else begin
            rsp_reg.done        <= 1'b0;
            rsp_reg.sram_write  <= 1'b0;
            rsp_reg.snoop_valid <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    rsp_reg.snoop_discard <= 1'b0;
                    if (cpu_go) begin
                        req_reg <= cpu_req;
                        hit_reg <= in_hit;
                        rsp_reg.l1_allow     <= 1'b1;
                        rsp_reg.shared_force <= 1'b1;
                        rsp_reg.from_array   <= 1'b0;
                        if (in_hit && !cpu_req.write) begin
                            hits_reg <= hits_reg + 32'h1;
                        end
                        if (cpu_req.write) begin
                            mreq_reg.valid      <= 1'b1;
                            mreq_reg.cycle      <= CYC_WRITE_THRU;
                            mreq_reg.addr       <= cpu_req.addr;
                            mreq_reg.data       <= cpu_req.data;
                            mreq_reg.be         <= cpu_req.be;
                            mreq_reg.whole_line <= 1'b0;
                            last_cyc_reg        <= CYC_WRITE_THRU;
                            state_reg           <= ST_WRITE;
                        end else if (in_hit) begin
                            last_next_reg <= in_st;
                            last_tro_reg  <= tro_arr[in_idx];
                            if ((in_st == MESI_S && cpu_req.lock) || (in_st != MESI_S && in_sl)) begin
                                mreq_reg.valid      <= 1'b1;
                                mreq_reg.cycle      <= CYC_READ_THRU;
                                mreq_reg.addr       <= cpu_req.addr;
                                mreq_reg.be         <= cpu_req.be;
                                mreq_reg.whole_line <= 1'b0;
                                rsp_reg.from_array  <= (in_st == MESI_M);
                                last_cyc_reg        <= CYC_READ_THRU;
                                state_reg           <= ST_THRU;
                            end else begin
                                rsp_reg.done  <= 1'b1;
                                last_cyc_reg  <= CYC_NONE;
                                if (in_st == MESI_M) begin
                                    rsp_reg.shared_force <= 1'b0;
                                    rsp_reg.from_array   <= 1'b1;
                                end else if (in_st == MESI_S) begin
                                    rsp_reg.l1_allow <= !(tro_arr[in_idx] && cpu_req.dat);
                                    rsp_reg.from_array <= 1'b1;
                                end else begin
                                    rsp_reg.from_array <= 1'b1;
                                end
                            end
                        end else if (in_st == MESI_M) begin
                            // inquire with discard before the dirty victim leaves
                            rsp_reg.snoop_valid   <= 1'b1;
                            rsp_reg.snoop_discard <= 1'b1;
                            rsp_reg.snoop_addr    <= 32'h0;
                            rsp_reg.snoop_addr[LINE_LSB +: SET_BITS] <= in_idx;
                            rsp_reg.snoop_addr[TAG_LSB +: TAG_W] <= tag_arr[in_idx];
                            state_reg <= ST_INQ;
                        end else begin
                            mreq_reg.valid      <= 1'b1;
                            mreq_reg.addr       <= cpu_req.addr;
                            mreq_reg.be         <= cpu_req.be;
                            mreq_reg.whole_line <= !(cpu_req.page_cache_disable || in_sl);
                            if (cpu_req.page_cache_disable || in_sl) begin
                                mreq_reg.cycle <= CYC_NC_READ;
                                last_cyc_reg   <= CYC_NC_READ;
                            end else begin
                                mreq_reg.cycle <= CYC_LINE_FILL;
                                last_cyc_reg   <= CYC_LINE_FILL;
                            end
                            state_reg <= ST_FETCH;
                        end
                    end else if (purge_take) begin
                        rsp_reg.snoop_valid   <= 1'b1;
                        rsp_reg.snoop_discard <= 1'b1;
                        rsp_reg.snoop_addr    <= purge_addr;
                        st_arr[purge_idx_reg]  <= MESI_I;
                        tro_arr[purge_idx_reg] <= 1'b0;
                    end else if (tdw_take) begin
                        st_arr[tag_sel_reg]  <= lmr_mesi_e'(tdw_data_reg[TD_ST_LSB +: 2]);
                        tro_arr[tag_sel_reg] <= tdw_data_reg[TD_TRO_BIT];
                        tag_arr[tag_sel_reg] <= tdw_data_reg[TD_TAG_LSB +: TAG_W];
                    end
                end
                ST_INQ: begin
                    rsp_reg.snoop_discard <= 1'b0;
                    mreq_reg.valid      <= 1'b1;
                    mreq_reg.cycle      <= CYC_COPY_BACK;
                    mreq_reg.addr       <= victim_addr;
                    mreq_reg.be         <= 4'hf;
                    mreq_reg.whole_line <= 1'b1;
                    last_cyc_reg        <= CYC_COPY_BACK;
                    state_reg           <= ST_COPY;
                end
                ST_COPY: begin
                    if (mem_rsp.done) begin
                        st_arr[rq_idx]  <= MESI_I;
                        tro_arr[rq_idx] <= 1'b0;
                        mreq_reg.addr   <= req_reg.addr;
                        mreq_reg.be     <= req_reg.be;
                        mreq_reg.whole_line <= !(req_reg.page_cache_disable || rq_sl);
                        if (req_reg.page_cache_disable || rq_sl) begin
                            mreq_reg.cycle <= CYC_NC_READ;
                            last_cyc_reg   <= CYC_NC_READ;
                        end else begin
                            mreq_reg.cycle <= CYC_LINE_FILL;
                            last_cyc_reg   <= CYC_LINE_FILL;
                        end
                        state_reg <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    if (mem_rsp.done) begin
                        mreq_reg.valid <= 1'b0;
                        rsp_reg.done   <= 1'b1;
                        if (fill_nc) begin
                            rsp_reg.l1_allow <= 1'b0;
                            last_next_reg    <= MESI_I;
                            last_tro_reg     <= 1'b0;
                            last_cyc_reg     <= CYC_NC_READ;
                        end else begin
                            st_arr[rq_idx]     <= fill_st;
                            tro_arr[rq_idx]    <= mem_rsp.memory_readonly_hint;
                            tag_arr[rq_idx]    <= rq_tag;
                            rsp_reg.sram_write <= 1'b1;
                            rsp_reg.l1_allow   <= !(mem_rsp.memory_readonly_hint && req_reg.dat);
                            last_next_reg      <= fill_st;
                            last_tro_reg       <= mem_rsp.memory_readonly_hint;
                        end
                    end
                end
                ST_THRU: begin
                    if (mem_rsp.done) begin
                        mreq_reg.valid   <= 1'b0;
                        rsp_reg.done     <= 1'b1;
                        rsp_reg.l1_allow <= 1'b0;
                    end
                end
                ST_WRITE: begin
                    if (mem_rsp.done) begin
                        rsp_reg.sram_write <= hit_reg;
                        if (write_miss_fill_ok) begin
                            mreq_reg.cycle      <= CYC_WMISS_FILL;
                            mreq_reg.addr       <= req_reg.addr;
                            mreq_reg.whole_line <= 1'b1;
                            last_cyc_reg        <= CYC_WMISS_FILL;
                            state_reg           <= ST_WRITE_MISS_FILL;
                        end else begin
                            mreq_reg.valid <= 1'b0;
                            rsp_reg.done   <= 1'b1;
                            state_reg      <= ST_IDLE;
                        end
                    end
                end
                ST_WRITE_MISS_FILL: begin
                    if (mem_rsp.done) begin
                        mreq_reg.valid     <= 1'b0;
                        rsp_reg.done       <= 1'b1;
                        st_arr[rq_idx]     <= fill_st;
                        tro_arr[rq_idx]    <= mem_rsp.memory_readonly_hint;
                        tag_arr[rq_idx]    <= rq_tag;
                        rsp_reg.sram_write <= 1'b1;
                        last_next_reg      <= fill_st;
                        last_tro_reg       <= mem_rsp.memory_readonly_hint;
                        state_reg          <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
            if ((state_reg == ST_FETCH || state_reg == ST_THRU) && mem_rsp.done) begin
                state_reg <= ST_IDLE;
            end
        end
    end

    // apb slave, zero wait states
    logic        apb_setup;
    logic        apb_wr;
    logic [7:0]  apb_off;
    logic        apb_hit;
    logic [31:0] rd_word;

    always_comb begin
        apb_setup = psel && !penable;
        apb_wr    = psel && penable && pready_reg && pwrite && !pslverr_reg;
        apb_off   = paddr[7:0];
        apb_hit   = (paddr[31:8] == 24'h0) && (paddr[1:0] == 2'b00)
                    && (apb_off <= ADDR_HITS);
        rd_word   = 32'h0;
        case (apb_off)
            ADDR_CTRL: begin
                rd_word[CTRL_EN_BIT]    = en_reg;
                rd_word[CTRL_PURGE_BIT] = purge_pend_reg;
                rd_word[11:8]           = purge_idx_reg;
            end
            ADDR_STATUS: begin
                rd_word[SR_NEXT_LSB +: 2]  = last_next_reg;
                rd_word[SR_CYC_LSB +: 4]   = last_cyc_reg;
                rd_word[SR_TRO_BIT]        = last_tro_reg;
                rd_word[SR_STATE_LSB +: 3] = state_reg;
            end
            ADDR_TAG_SEL: begin
                rd_word[3:0] = tag_sel_reg;
            end
            ADDR_TAG_DATA: begin
                rd_word[TD_TAG_LSB +: TAG_W] = tag_arr[tag_sel_reg];
                rd_word[TD_TRO_BIT]          = tro_arr[tag_sel_reg];
                rd_word[TD_ST_LSB +: 2]      = st_arr[tag_sel_reg];
            end
            ADDR_HITS: begin
                rd_word = hits_reg;
            end
            default: begin
                rd_word = 32'h0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_reg     <= 1'b0;
            pslverr_reg    <= 1'b0;
            prdata_reg     <= 32'h0;
            en_reg         <= CTRL_EN_RESET;
            tag_sel_reg    <= TAG_SEL_RESET;
            purge_pend_reg <= 1'b0;
            purge_idx_reg  <= 4'h0;
            tdw_pend_reg   <= 1'b0;
            tdw_data_reg   <= 32'h0;
        end else begin
            pready_reg  <= apb_setup;
            pslverr_reg <= apb_setup && !apb_hit;
            if (apb_setup) begin
                prdata_reg <= apb_hit ? rd_word : 32'h0;
            end
            // a new command wins over the sequencer taking the old one
            purge_pend_reg <= (purge_pend_reg && !purge_take)
                              || (apb_wr && apb_off == ADDR_CTRL && pwdata[CTRL_PURGE_BIT]);
            tdw_pend_reg   <= (tdw_pend_reg && !tdw_take)
                              || (apb_wr && apb_off == ADDR_TAG_DATA);
            if (apb_wr && apb_off == ADDR_CTRL) begin
                en_reg <= pwdata[CTRL_EN_BIT];
                if (pwdata[CTRL_PURGE_BIT]) begin
                    purge_idx_reg <= pwdata[11:8];
                end
            end
            if (apb_wr && apb_off == ADDR_TAG_SEL) begin
                tag_sel_reg <= pwdata[3:0];
            end
            if (apb_wr && apb_off == ADDR_TAG_DATA) begin
                tdw_data_reg <= pwdata;
            end
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign cpu_rsp = rsp_reg;
    assign mem_req = mreq_reg;

endmodule
